// [dpss_pkg.sv]
package dpss_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_DIV = 2;
  localparam int OSC_PERIOD_NS = 500;
  localparam int OSC_PERIOD_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SYNC_LOSS_NS = 10000;
  localparam int SYNC_LOSS_CYC = SYNC_LOSS_NS / CLK_PERIOD_NS;
  localparam int PER_W = 16;
  localparam int SS_STEPS = 64;
  localparam int SS_TOTAL_OSC = 2048;
  localparam int SS_PRESCALE = SS_TOTAL_OSC / SS_STEPS;
  localparam int SS_W = 7;
  localparam int PRE_W = 5;
  localparam int DMAX_NUM = 88;
  localparam int DMAX_DEN = 100;
  localparam int FOLD_W = 2;
  localparam int PHASE_DEG = 45;
  localparam int FULL_DEG = 360;
  localparam int NCH = 2;
  localparam int CH_IN_W = 5;

  typedef struct packed {
    logic enable;
    logic duty_met;
    logic current_trip;
    logic feedback_level_low;
    logic output_ok;
  } dpss_ch_in_t;

  typedef struct packed {
    logic switch_on;
    logic output_good_flag;
    logic ss_done;
    logic [SS_W-1:0] ref_level;
  } dpss_ch_out_t;
endpackage

// [dpss_plant.sv]
`timescale 1ns/1ns
module dpss_plant (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // switch drive as the power stage sees it
  input wire logic [1:0] sw_on,
  // scenario controls
  input wire logic [7:0] duty_delay,
  input wire logic trip_req,
  input wire logic sync_run,
  input wire logic [7:0] sync_half,
  // comparator and sync outputs
  output logic [1:0] duty_met,
  output logic [1:0] current_trip,
  output logic sync_in
);
  logic [7:0] on_cnt [2];
  logic [7:0] half_cnt;

  // ramp comparator: trips a set time into each on-time, zero means never
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      on_cnt <= '{8'h00, 8'h00};
      duty_met <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        on_cnt[c] <= sw_on[c] ? on_cnt[c] + 8'h01 : 8'h00;
        duty_met[c] <= sw_on[c] && duty_delay != 8'h00 && on_cnt[c] + 8'h01 >= duty_delay;
      end
    end
  end

  // peak current can only exceed the limit while the switch conducts
  assign current_trip = {2{trip_req}} & sw_on;

  // stands in for a master's phase clock: 50 percent duty, idle low when stopped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_in <= 1'b0;
      half_cnt <= 8'h00;
    end else if (!sync_run) begin
      sync_in <= 1'b0;
      half_cnt <= 8'h00;
    end else if (half_cnt == sync_half - 8'h01) begin
      sync_in <= !sync_in;
      half_cnt <= 8'h00;
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end
endmodule

// [dpss_softstart.sv]
`timescale 1ns/1ns
module dpss_softstart (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic clear,
  input wire logic tick,
  // reference ramp
  output logic [dpss_pkg::SS_W-1:0] ref_level,
  output logic done
);
  logic [dpss_pkg::PRE_W-1:0] pre_reg;
  localparam logic [dpss_pkg::PRE_W-1:0] PRE_LAST = dpss_pkg::PRE_W'(dpss_pkg::SS_PRESCALE - 1);
  localparam logic [dpss_pkg::SS_W-1:0] STEP_LAST = dpss_pkg::SS_W'(dpss_pkg::SS_STEPS);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  assign done = (ref_level == STEP_LAST);

  // prescaler of internal oscillator cycles, restarts with the ramp
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= '0;
    end else if (clear || done) begin
      pre_reg <= '0;
    end else if (tick) begin
      pre_reg <= (pre_reg == PRE_LAST) ? '0 : pre_reg + 1'b1;
    end
  end

  // step counter, 64 steps of 32 cycles, parks at full scale
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_level <= '0;
    end else if (clear) begin
      ref_level <= '0;
    end else if (tick && pre_reg == PRE_LAST && !done) begin
      ref_level <= ref_level + 1'b1;
    end
  end

  ramp_step_a: assert property (
    (tick && pre_reg == PRE_LAST && !done && !clear) |=> ref_level == $past(ref_level) + 7'h01)
    else $error("ramp did not step after 32 ticks");
  ramp_hold_a: assert property (
    (done && !clear) |=> ref_level == STEP_LAST)
    else $error("ramp left final step");
endmodule

// [dpss_sync2.sv]
`timescale 1ns/1ns
module dpss_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // async in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// [dpss_top.sv]
`timescale 1ns/1ns
module dpss_top (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // oscillator and sync pins
  input wire logic sync_in,
  output logic phase_clock_out,
  output logic ext_sync_active,
  // supervisors
  input wire logic supply_lockout,
  input wire logic thermal_stop,
  // per-channel analog indications and outputs
  input wire dpss_pkg::dpss_ch_in_t [dpss_pkg::NCH-1:0] ch_in,
  output dpss_pkg::dpss_ch_out_t [dpss_pkg::NCH-1:0] ch_out
);
  localparam int SW = dpss_pkg::PER_W;
  localparam int IW = dpss_pkg::NCH * dpss_pkg::CH_IN_W + 3;
  localparam logic [SW-1:0] OSC_LAST = SW'(dpss_pkg::OSC_PERIOD_CYC - 1);
  localparam logic [SW-1:0] LOSS_LAST = SW'(dpss_pkg::SYNC_LOSS_CYC - 1);
  localparam logic [SW-1:0] PER_MAX = '1;

  // synchronised copies of every pin input
  logic [IW-1:0] raw_in;
  logic [IW-1:0] sync_out;
  logic sync_s;
  logic lockout_s;
  logic thermal_s;
  dpss_pkg::dpss_ch_in_t [dpss_pkg::NCH-1:0] chs;

  // oscillator selection and division
  logic sync_d_reg;
  logic sync_rise;
  logic [SW-1:0] sync_wd_reg;
  logic ext_active_reg;
  logic [SW-1:0] int_cnt_reg;
  logic int_tick;
  logic osc_tick;
  logic sw_clk_reg;
  logic sw_rise;
  logic sw_fall;
  logic [SW-1:0] osc_cnt_reg;
  logic [SW-1:0] osc_per_reg;
  logic [SW-1:0] max_on;
  logic [SW-1:0] per_next;
  logic [SW-1:0] cap_next;
  logic [SW-1:0] quarter;
  logic [SW-1:0] ph_cnt_reg;
  logic ph_clk_reg;

  // channel state
  logic [dpss_pkg::NCH-1:0] run_ok;
  logic [dpss_pkg::NCH-1:0] turn_edge;
  logic [dpss_pkg::NCH-1:0] turn_on;
  logic [dpss_pkg::NCH-1:0] on_reg;
  logic [dpss_pkg::NCH-1:0] good_reg;
  logic [SW-1:0] on_cnt_reg [dpss_pkg::NCH];
  logic [dpss_pkg::FOLD_W-1:0] fold_cnt_reg [dpss_pkg::NCH];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // every pin goes through two flops before use
  assign raw_in = {sync_in, supply_lockout, thermal_stop, ch_in};
  dpss_sync2 #(
    .W(IW)
  ) u_pin_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d(raw_in),
    .q(sync_out)
  );
  assign sync_s = sync_out[IW-1];
  assign lockout_s = sync_out[IW-2];
  assign thermal_s = sync_out[IW-3];
  assign chs = sync_out[IW-4:0];

  // sync rising edge detect on the settled copy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_d_reg <= 1'b0;
    end else begin
      sync_d_reg <= sync_s;
    end
  end
  assign sync_rise = sync_s && !sync_d_reg;

  // watchdog: external clock counts as present while edges keep coming
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_wd_reg <= '0;
      ext_active_reg <= 1'b0;
    end else if (sync_rise) begin
      sync_wd_reg <= '0;
      ext_active_reg <= 1'b1;
    end else if (sync_wd_reg == LOSS_LAST) begin
      ext_active_reg <= 1'b0;
    end else begin
      sync_wd_reg <= sync_wd_reg + 1'b1;
    end
  end
  assign ext_sync_active = ext_active_reg;

  // internal oscillator free-runs so the soft-start timebase never depends on sync
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_cnt_reg <= '0;
    end else begin
      int_cnt_reg <= (int_cnt_reg == OSC_LAST) ? '0 : int_cnt_reg + 1'b1;
    end
  end
  assign int_tick = (int_cnt_reg == OSC_LAST);

  // selected oscillator edge
  assign osc_tick = ext_active_reg ? sync_rise : int_tick;

  // divide by two: one switching period spans two oscillator periods
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_clk_reg <= 1'b0;
    end else if (osc_tick) begin
      sw_clk_reg <= !sw_clk_reg;
    end
  end
  assign sw_rise = osc_tick && !sw_clk_reg;
  assign sw_fall = osc_tick && sw_clk_reg;

  // measure the oscillator period in clk cycles, saturating when stalled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_reg <= '0;
      osc_per_reg <= SW'(dpss_pkg::OSC_PERIOD_CYC);
    end else if (osc_tick) begin
      osc_cnt_reg <= '0;
      osc_per_reg <= osc_cnt_reg + 1'b1;
    end else if (osc_cnt_reg != PER_MAX) begin
      osc_cnt_reg <= osc_cnt_reg + 1'b1;
    end
  end

  // 0.88 of the switching period, and 45 degrees of it for the clock output
  assign max_on = SW'(32'(osc_per_reg) * 32'(dpss_pkg::OSC_DIV * dpss_pkg::DMAX_NUM)
                  / 32'(dpss_pkg::DMAX_DEN));
  assign quarter = SW'(32'(osc_per_reg) * 32'(dpss_pkg::OSC_DIV * dpss_pkg::PHASE_DEG)
                   / 32'(dpss_pkg::FULL_DEG));

  // cap of the period being loaded, so a shorter new period cuts a long pulse in time
  assign per_next = osc_tick ? osc_cnt_reg + 1'b1 : osc_per_reg;
  assign cap_next = SW'(32'(per_next) * 32'(dpss_pkg::OSC_DIV * dpss_pkg::DMAX_NUM)
                    / 32'(dpss_pkg::DMAX_DEN));

  // clock output copies the switching clock a quarter oscillator period late
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_cnt_reg <= '0;
      ph_clk_reg <= 1'b0;
    end else if (osc_tick) begin
      ph_cnt_reg <= '0;
    end else begin
      if (ph_cnt_reg != PER_MAX) begin
        ph_cnt_reg <= ph_cnt_reg + 1'b1;
      end
      if (ph_cnt_reg == quarter) begin
        ph_clk_reg <= sw_clk_reg;
      end
    end
  end
  assign phase_clock_out = ph_clk_reg;

  // per-channel on-time, foldback and soft-start
  for (genvar i = 0; i < dpss_pkg::NCH; i++) begin : g_ch
    // lockout, thermal stop and enable all gate the switch and the ramp
    assign run_ok[i] = !lockout_s && !thermal_s && chs[i].enable;
    assign turn_edge[i] = (i == 0) ? sw_rise : sw_fall;
    // in deep overload only one edge in four turns the switch on
    assign turn_on[i] = turn_edge[i] && run_ok[i]
                        && (!chs[i].feedback_level_low || fold_cnt_reg[i] == '0);

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        fold_cnt_reg[i] <= '0;
      end else if (!chs[i].feedback_level_low) begin
        fold_cnt_reg[i] <= '0;
      end else if (turn_edge[i]) begin
        fold_cnt_reg[i] <= fold_cnt_reg[i] + 1'b1;
      end
    end

    // turn-on edge wins over a stale duty or limit flag from the last cycle
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        on_reg[i] <= 1'b0;
      end else if (!run_ok[i]) begin
        on_reg[i] <= 1'b0;
      end else if (turn_on[i]) begin
        on_reg[i] <= 1'b1;
      end else if (chs[i].current_trip) begin
        on_reg[i] <= 1'b0;
      end else if (chs[i].duty_met || on_cnt_reg[i] >= cap_next - 1'b1) begin
        on_reg[i] <= 1'b0;
      end
    end

    // on-time counter in clk cycles
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        on_cnt_reg[i] <= '0;
      end else if (turn_on[i] || !on_reg[i]) begin
        on_cnt_reg[i] <= '0;
      end else if (on_cnt_reg[i] != PER_MAX) begin
        on_cnt_reg[i] <= on_cnt_reg[i] + 1'b1;
      end
    end

    // good flag follows the comparator only while the channel may run
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        good_reg[i] <= 1'b0;
      end else begin
        good_reg[i] <= chs[i].output_ok && run_ok[i];
      end
    end

    // ramp uses the internal oscillator, not the halved switching clock
    dpss_softstart u_ss (
      .clk(clk),
      .arst_n(arst_n),
      .clear(!run_ok[i]),
      .tick(int_tick),
      .ref_level(ch_out[i].ref_level),
      .done(ch_out[i].ss_done)
    );

    assign ch_out[i].switch_on = on_reg[i];
    assign ch_out[i].output_good_flag = good_reg[i];

    turn_on_a: assert property (
      (turn_edge[i] && run_ok[i] && !chs[i].feedback_level_low
       && !$past(lockout_s) && !lockout_s) |=> on_reg[i])
      else $error("switch missed its turn-on edge");
    limit_off_a: assert property (
      (chs[i].current_trip && !turn_on[i]) |=> !on_reg[i])
      else $error("current limit did not end on-time");
    max_duty_a: assert property (
      on_reg[i] |-> on_cnt_reg[i] < max_on)
      else $error("on-time passed the 0.88 cap");
    fold_skip_a: assert property (
      (!on_reg[i] && turn_edge[i] && chs[i].feedback_level_low
       && fold_cnt_reg[i] != 2'h0) |=> !on_reg[i])
      else $error("foldback turned on off its quarter edge");
    enable_reset_a: assert property (
      !chs[i].enable |=> !on_reg[i] && ch_out[i].ref_level == 7'h00)
      else $error("enable low left switch or ramp active");
    thermal_stop_a: assert property (
      thermal_s |=> !on_reg[i] && !good_reg[i] && ch_out[i].ref_level == 7'h00)
      else $error("thermal stop not honoured");

    // a switch only rises on its own turn-on edge, and held-off channels stay cleared
    edge_only_a: assert property (
      (!on_reg[i] && !turn_on[i]) |=> !on_reg[i])
      else $error("switch rose away from its turn-on edge");
    ramp_clear_a: assert property (
      !run_ok[i] |=> ch_out[i].ref_level == 7'h00 && !ch_out[i].ss_done)
      else $error("ramp ran while the channel was held off");
    fold_clear_a: assert property (
      !chs[i].feedback_level_low |=> fold_cnt_reg[i] == 2'h0)
      else $error("foldback count kept without overload");
    good_low_a: assert property (
      !run_ok[i] |=> !good_reg[i])
      else $error("good flag high while channel held off");
  end

  div_two_a: assert property (
    osc_tick |=> sw_clk_reg != $past(sw_clk_reg))
    else $error("switching clock did not toggle on oscillator edge");
  phase_split_a: assert property (
    turn_edge[1] |-> !turn_edge[0] && $past(sw_clk_reg, 1) == sw_clk_reg && sw_clk_reg)
    else $error("second channel edge not on falling edge");
  sync_align_a: assert property (
    (ext_active_reg && sync_rise) |-> osc_tick)
    else $error("turn-on not aligned to sync edge");
  sync_loss_a: assert property (
    (!sync_rise && sync_wd_reg == LOSS_LAST) |=> !ext_active_reg ##0 (osc_tick == int_tick))
    else $error("no fallback to internal oscillator");
  phase_lag_a: assert property (
    $changed(ph_clk_reg) |-> $past(ph_cnt_reg) == $past(quarter))
    else $error("clock output edge not at 45 degrees");
  lockout_off_a: assert property (
    lockout_s |=> on_reg == 2'b00)
    else $error("lockout did not force switches off");

  // clock selection and division
  sync_take_a: assert property (
    sync_rise |=> ext_active_reg)
    else $error("sync edge did not select the external clock");
  ext_only_a: assert property (
    (ext_active_reg && !sync_rise) |-> !osc_tick)
    else $error("internal tick leaked through while sync selected");
  sw_hold_a: assert property (
    !osc_tick |=> $stable(sw_clk_reg))
    else $error("switching clock moved without an oscillator edge");
endmodule

// [test_dpss_top.sv]
`timescale 1ns/1ns
module test_dpss_top;
  localparam int LIMIT = 40000;
  localparam int PER = 2 * dpss_pkg::OSC_PERIOD_CYC;
  logic clk, arst_n, sync_in, phase_clock_out, ext_sync_active;
  logic supply_lockout, thermal_stop, trip_req, sync_run;
  logic [1:0] en, fb, ok, dm, ct, sw;
  logic [7:0] duty_delay, sync_half;
  dpss_pkg::dpss_ch_in_t [dpss_pkg::NCH-1:0] ch_in;
  dpss_pkg::dpss_ch_out_t [dpss_pkg::NCH-1:0] ch_out;
  int err_total, check_count, cyc, t0, t1, l0, l1, d, hi;

  dpss_top dpss_top_i (.clk(clk), .arst_n(arst_n), .sync_in(sync_in),
    .phase_clock_out(phase_clock_out), .ext_sync_active(ext_sync_active),
    .supply_lockout(supply_lockout), .thermal_stop(thermal_stop), .ch_in(ch_in), .ch_out(ch_out));
  dpss_plant dpss_plant_i (.clk(clk), .arst_n(arst_n), .sw_on(sw), .duty_delay(duty_delay),
    .trip_req(trip_req), .sync_run(sync_run), .sync_half(sync_half), .duty_met(dm),
    .current_trip(ct), .sync_in(sync_in));

  // channel inputs packed from bench levels and plant comparators
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      ch_in[c] = {en[c], dm[c], ct[c], fb[c], ok[c]};
      sw[c] = ch_out[c].switch_on;
    end
  end

  // clock generator
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end

  // cycle count doubles as hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  // waits for a fresh turn-on, returns its cycle and on-time length
  task automatic grab(input int ch, output int t, output int len);
    int n;
    n = 0;
    while (sw[ch] !== 1'b0 && n < 2000) begin @(negedge clk); n++; end
    while (sw[ch] !== 1'b1 && n < 2000) begin @(negedge clk); n++; end
    t = cyc;
    len = 0;
    while (sw[ch] === 1'b1 && len < 500) begin @(negedge clk); len++; end
  endtask

  // clock output lag: 45 degrees of two oscillator periods, plus the output register
  function automatic int lag_cycles(input int osc_cyc);
    return dpss_pkg::OSC_DIV * dpss_pkg::PHASE_DEG * osc_cyc / dpss_pkg::FULL_DEG + 1;
  endfunction

  // counts cycles with a masked switch on over a window
  task automatic quiet(input int n, input logic [1:0] m, output int h);
    h = 0;
    repeat (n) begin @(negedge clk); if ((sw & m) !== 2'b00) h++; end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    arst_n = 1'b0; supply_lockout = 1'b0; thermal_stop = 1'b0; trip_req = 1'b0;
    sync_run = 1'b0; en = 2'b11; fb = 2'b00; ok = 2'b11; duty_delay = 8'h00;
    sync_half = 8'h14; err_total = 0; check_count = 0; cyc = 0;
    void'($urandom(32'h9039));
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    // free running: period, max duty, second channel offset
    grab(0, t0, l0);
    grab(0, t0, l0);
    grab(0, t1, l1);
    check("period", t1 - t0, PER);
    check("max on", l1, PER * dpss_pkg::DMAX_NUM / dpss_pkg::DMAX_DEN);
    grab(1, t0, l0);
    check("ch1 offset", (t0 - t1) % PER, PER / 2);
    check("good flag", ch_out[0].output_good_flag, 1'b1);
    // phase clock lag after the turn-on edge
    grab(0, t0, l0);
    while (phase_clock_out !== 1'b1 && cyc < t0 + PER) @(negedge clk);
    while (phase_clock_out !== 1'b0 && cyc < t0 + 2 * PER) @(negedge clk);
    while (phase_clock_out !== 1'b1 && cyc < t0 + 3 * PER) @(negedge clk);
    check("phase lag", (cyc - t0) % PER, lag_cycles(dpss_pkg::OSC_PERIOD_CYC));
    // random commanded duty on both channels
    repeat (4) begin
      d = $urandom_range(10, 80);
      duty_delay = d[7:0];
      grab(0, t0, l0);
      grab(0, t0, l0);
      grab(1, t1, l1);
      check("duty ch0", l0 >= d + 1 && l0 <= d + 4, 1'b1);
      check("duty ch1", l1 >= d + 1 && l1 <= d + 4, 1'b1);
    end
    duty_delay = 8'h00;
    // current limit ends the on-time, next turn-on still on time
    trip_req = 1'b1;
    grab(0, t0, l0);
    grab(0, t0, l0);
    grab(0, t1, l1);
    check("trip len", l0 >= 1 && l0 <= 4, 1'b1);
    check("trip next", t1 - t0, PER);
    trip_req = 1'b0;
    // foldback: every fourth edge only
    fb = 2'b01;
    grab(0, t0, l0);
    grab(0, t0, l0);
    grab(0, t1, l1);
    check("fold period", t1 - t0, 4 * PER);
    fb = 2'b00;
    // lockout silences both, ramp cleared
    supply_lockout = 1'b1;
    repeat (5) @(negedge clk);
    quiet(3 * PER, 2'b11, hi);
    check("lockout on", hi, 0);
    check("lockout ref", ch_out[0].ref_level, 7'h00);
    supply_lockout = 1'b0;
    // thermal stop: both off, flags low, ramps reset
    thermal_stop = 1'b1;
    repeat (5) @(negedge clk);
    quiet(3 * PER, 2'b11, hi);
    check("thermal on", hi, 0);
    check("thermal good", {ch_out[1].output_good_flag, ch_out[0].output_good_flag}, 2'b00);
    check("thermal ref", ch_out[1].ref_level, 7'h00);
    thermal_stop = 1'b0;
    // enable low resets the ramp, then first step lands after 32 ticks
    en = 2'b10;
    repeat (5) @(negedge clk);
    check("en low ref", ch_out[0].ref_level, 7'h00);
    quiet(2 * PER, 2'b01, hi);
    check("en low sw", hi, 0);
    en = 2'b11;
    repeat (1500) @(negedge clk);
    check("ramp early", ch_out[0].ref_level, 7'h00);
    repeat (200) @(negedge clk);
    check("ramp step", ch_out[0].ref_level, 7'h01);
    check("ramp done", ch_out[0].ss_done, 1'b0);
    // external sync takes over, then is lost
    sync_half = 8'h14;
    sync_run = 1'b1;
    repeat (200) @(negedge clk);
    check("ext active", ext_sync_active, 1'b1);
    grab(0, t0, l0);
    grab(0, t1, l1);
    check("sync period", t1 - t0, 4 * sync_half);
    sync_run = 1'b0;
    repeat (dpss_pkg::SYNC_LOSS_CYC + 50) @(negedge clk);
    check("ext lost", ext_sync_active, 1'b0);
    grab(0, t0, l0);
    grab(0, t1, l1);
    check("back internal", t1 - t0, PER);
    tally_and_finish();
  end
endmodule
